// ===== rtl/kmjt_pkg.sv
// Constants and types for the keypad monitor, jog and teach controller.
// Assumes one 100 MHz clock and a Wishbone classic register bus.
package kmjt_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int SHOW_TIME_MS = 1000;
	localparam int SHOW_CYCLES = CLK_HZ / 1000 * SHOW_TIME_MS;
	localparam int CLR_TIME_MS = 2000;
	localparam int CLR_CYCLES = CLK_HZ / 1000 * CLR_TIME_MS;
	localparam int DEB_TIME_MS = 10;
	localparam int DEB_CYCLES = CLK_HZ / 1000 * DEB_TIME_MS;
	localparam int NUM_KEYS = 5;
	localparam int KEY_UP = 0;
	localparam int KEY_DOWN = 1;
	localparam int KEY_MODE = 2;
	localparam int KEY_ENTER = 3;
	localparam int KEY_NEXT = 4;
	localparam logic [4:0] MON_MAX = 5'h10;
	localparam logic [4:0] MON_SPEED = 5'h06;
	localparam logic [4:0] MON_RESET = 5'h00;
	localparam logic [3:0] AUX_TEACH = 4'h4;
	localparam int NUM_FAULTS = 5;
	localparam int NUM_SLOTS = 8;
	localparam logic [7:0] ADR_MONSEL = 8'h00;
	localparam logic [7:0] ADR_AUXFN = 8'h04;
	localparam logic [7:0] ADR_JOGSPD = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0C;
	localparam logic [7:0] ADR_FAULT = 8'h10;
	localparam logic [7:0] ADR_SLOT = 8'h40;
	localparam int STAT_JOG = 0;
	localparam int STAT_TEACH = 1;
	localparam int STAT_SHOW = 2;
	localparam int STAT_HIST = 3;
	typedef enum {
		KMJT_SHOW, KMJT_MONITOR, KMJT_HIST, KMJT_JOG
	} kmjt_mode_e;
	typedef struct packed {
		logic driveEnable;
		logic faultStop;
		logic errorPresent;
		logic profileActive;
	} kmjt_drive_s;
	typedef struct packed {
		logic [15:0] revs;
		logic [15:0] counts;
	} kmjt_pos_s;
	typedef struct packed {
		logic [4:0] digit;
		logic [4:0] point;
		logic minus;
	} kmjt_fmt_s;
endpackage : kmjt_pkg

// ===== rtl/kmjt_key_filter.sv
// Debounce and press-edge detector for one front panel key.
// Assumes an asynchronous key pin; synchronised here.
`timescale 1ns/10ps
module kmjt_key_filter #(
	parameter int DEB = 1_000_000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic keyPin,
	output logic level,
	output logic press
);
	logic s0;
	logic s1;
	logic [$clog2(DEB+1)-1:0] cnt;
	wire differ = s1 != level;
	wire done = cnt == ($bits(cnt))'(DEB - 1);
	always_ff @(posedge clk) begin
		s0 <= keyPin;
		s1 <= s0;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt <= '0;
			level <= 1'b0;
			press <= 1'b0;
		end else begin
			press <= differ && done && s1;
			if (!differ)
				cnt <= '0;
			else if (done) begin
				cnt <= '0;
				level <= s1;
			end else
				cnt <= cnt + 1'b1;
		end
	end
endmodule : kmjt_key_filter

// ===== rtl/kmjt_top.sv
// Keypad monitor select, display format, fault history, jog and teach.
// Assumes Wishbone classic slave registers; keys arrive from panel pins.
`timescale 1ns/10ps
module kmjt_top #(
	parameter int SHOW_CNT = kmjt_pkg::SHOW_CYCLES,
	parameter int CLR_CNT = kmjt_pkg::CLR_CYCLES,
	parameter int DEB_CNT = kmjt_pkg::DEB_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [kmjt_pkg::NUM_KEYS-1:0] keyPins,
	input wire kmjt_pkg::kmjt_drive_s drive,
	input wire logic [4:0] monSelStored,
	input wire logic faultEvent,
	input wire logic [7:0] faultCode,
	input wire logic signed [19:0] monValue,
	input wire logic [2:0] monFracDigits,
	input wire logic monFiveDigit,
	input wire kmjt_pkg::kmjt_pos_s absPos,
	output logic [4:0] monSelect,
	output logic [19:0] dispValue,
	output kmjt_pkg::kmjt_fmt_s dispFmt,
	output logic dispShowCode,
	output logic dispJogPrompt,
	output logic [3:0] dispSlot,
	output logic [7:0] dispFault,
	output logic faultClear,
	output logic jogCw,
	output logic jogCcw,
	output logic [15:0] jogSpeed,
	output logic jogOverride,
	output logic slotWrite,
	output logic [2:0] slotIndex,
	output kmjt_pkg::kmjt_pos_s slotData
);
	import kmjt_pkg::*;

	logic [NUM_KEYS-1:0] keyLevel;
	logic [NUM_KEYS-1:0] keyPress;
	for (genvar k = 0; k < NUM_KEYS; k++) begin : g_key
		kmjt_key_filter #(.DEB(DEB_CNT)) u_key (
			.clk(clk),
			.rst_n(rst_n),
			.keyPin(keyPins[k]),
			.level(keyLevel[k]),
			.press(keyPress[k])
		);
	end

	kmjt_mode_e mode;
	logic [31:0] showCnt;
	logic [31:0] clrCnt;
	logic [3:0] auxFn;
	logic [2:0] histIdx;
	logic [2:0] slot;
	logic teachMode;
	logic [7:0] faults [NUM_FAULTS];
	kmjt_pos_s slots [NUM_SLOTS];
	logic busy;

	wire upP = keyPress[KEY_UP];
	wire dnP = keyPress[KEY_DOWN];
	wire modeP = keyPress[KEY_MODE];
	wire entP = keyPress[KEY_ENTER];
	wire nextP = keyPress[KEY_NEXT];
	wire upL = keyLevel[KEY_UP];
	wire dnL = keyLevel[KEY_DOWN];
	wire bothHeld = upL && dnL;

	// Bus decode
	wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wbWr = wbReq && wb_we_i;
	wire selLow = wb_sel_i[0];
	wire wrMon = wbWr && selLow && wb_adr_i == ADR_MONSEL;
	wire wrAux = wbWr && selLow && wb_adr_i == ADR_AUXFN;
	wire wrJog = wbWr && wb_sel_i[1:0] == 2'h3 && wb_adr_i == ADR_JOGSPD;
	wire isFault = wb_adr_i >= ADR_FAULT
		&& wb_adr_i < ADR_FAULT + 8'(NUM_FAULTS * 4);
	wire isSlot = wb_adr_i >= ADR_SLOT
		&& wb_adr_i < ADR_SLOT + 8'(NUM_SLOTS * 4);
	wire [2:0] fIdx = 3'((wb_adr_i - ADR_FAULT) >> 2);
	wire [2:0] sIdx = 3'(wb_adr_i[4:2]);
	wire [31:0] statusWord = {28'h0, mode == KMJT_HIST,
		mode == KMJT_SHOW, teachMode, mode == KMJT_JOG};

	// Jog permission and key direction
	wire jogOk = !drive.errorPresent && drive.driveEnable
		&& !drive.faultStop;
	wire inJog = mode == KMJT_JOG;
	wire next_jogCw = inJog && jogOk && dnL && !upL;
	wire next_jogCcw = inJog && jogOk && upL && !dnL;

	// Monitor select step with wrap at the top code
	wire [4:0] monUp = monSelect == MON_MAX ? 5'h00 : monSelect + 5'h01;
	wire [4:0] monDn = monSelect == 5'h00 ? MON_MAX : monSelect - 5'h01;
	wire monStoredOk = monSelStored <= MON_MAX;

	// Display format of the monitored value
	wire neg = monValue < 0;
	wire [19:0] mag = neg ? 20'(-monValue) : monValue;
	wire [4:0] fracPoint = monFracDigits == 3'h0 ? 5'h00
		: 5'(5'h01 << monFracDigits);
	wire [4:0] next_point = (neg && monFiveDigit) ? 5'h1F
		: fracPoint;
	wire next_minus = neg && !monFiveDigit;

	always_ff @(posedge clk) begin
		if (!rst_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wbReq;
	end

	// Read data select
	wire rdReq = wbReq && !wb_we_i;
	wire [31:0] rdData = wb_adr_i == ADR_MONSEL ? {27'h0, monSelect}
		: wb_adr_i == ADR_AUXFN ? {28'h0, auxFn}
		: wb_adr_i == ADR_JOGSPD ? {16'h0, jogSpeed}
		: wb_adr_i == ADR_STATUS ? statusWord
		: isFault ? {24'h0, faults[fIdx]}
		: isSlot ? slots[sIdx]
		: 32'h0;
	always_ff @(posedge clk) begin
		if (!rst_n)
			wb_dat_o <= 32'h0;
		else if (rdReq)
			wb_dat_o <= rdData;
	end

	// Mode sequencer conditions
	wire inShow = mode == KMJT_SHOW;
	wire inMon = mode == KMJT_MONITOR;
	wire inHist = mode == KMJT_HIST;
	wire showLoad = inShow && showCnt == 32'h0 && monStoredOk;
	wire showDone = inShow && showCnt == 32'(SHOW_CNT - 1);
	wire monStepUp = inMon && upP && !dnL;
	wire monStepDn = inMon && dnP && !upL;
	wire monWrOk = wrMon && wb_dat_i[4:0] <= MON_MAX;
	wire histEnter = inMon && entP;
	wire histStep = inHist && upP;
	wire histLeave = inHist && modeP;
	wire jogEnter = wrJog && !inShow;
	wire jogLeave = inJog && modeP;
	wire [2:0] histNext = histIdx == 3'(NUM_FAULTS - 1)
		? 3'h0 : histIdx + 3'h1;

	always_ff @(posedge clk) begin
		if (!rst_n)
			showCnt <= 32'h0;
		else if (!inShow || showDone)
			showCnt <= 32'h0;
		else
			showCnt <= showCnt + 32'h1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			mode <= KMJT_SHOW;
		else begin
			unique case (mode)
				KMJT_SHOW: begin
					if (showDone)
						mode <= KMJT_MONITOR;
				end
				KMJT_MONITOR: begin
					if (jogEnter)
						mode <= KMJT_JOG;
					else if (histEnter)
						mode <= KMJT_HIST;
				end
				KMJT_HIST: begin
					if (jogEnter)
						mode <= KMJT_JOG;
					else if (histLeave)
						mode <= KMJT_MONITOR;
				end
				KMJT_JOG: begin
					if (jogLeave)
						mode <= KMJT_MONITOR;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			monSelect <= MON_RESET;
		else if (monWrOk)
			monSelect <= wb_dat_i[4:0];
		else if (showLoad)
			monSelect <= monSelStored;
		else if (monStepUp)
			monSelect <= monUp;
		else if (monStepDn)
			monSelect <= monDn;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			histIdx <= 3'h0;
		else if (histEnter || (jogEnter && inHist))
			histIdx <= 3'h0;
		else if (histStep)
			histIdx <= histNext;
	end

	// Auxiliary function, jog speed, teach slot; function and speed written over the bus
	wire teachStep = inJog && teachMode && (entP || nextP);
	always_ff @(posedge clk) begin
		if (!rst_n)
			auxFn <= 4'h0;
		else if (wrAux)
			auxFn <= wb_dat_i[3:0];
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			jogSpeed <= 16'h0;
		else if (wrJog)
			jogSpeed <= wb_dat_i[15:0];
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			teachMode <= 1'b0;
		else if (jogLeave)
			teachMode <= 1'b0;
		else if (wrJog)
			teachMode <= auxFn == AUX_TEACH;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			slot <= 3'h0;
		else if (wrJog)
			slot <= 3'h0;
		else if (teachStep)
			slot <= slot + 3'h1;
	end

	// Teach store into slot pairs; storage kept across position resets
	wire storeNow = inJog && teachMode && entP;
	always_ff @(posedge clk) begin
		if (storeNow)
			slots[slot] <= absPos;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			slotWrite <= 1'b0;
		else
			slotWrite <= storeNow;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			slotIndex <= 3'h0;
			slotData <= '0;
		end else if (storeNow) begin
			slotIndex <= slot;
			slotData <= absPos;
		end
	end

	// Fault log, newest in entry zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_FAULTS; i++)
				faults[i] <= 8'h00;
		end else if (faultEvent) begin
			faults[0] <= faultCode;
			for (int i = 1; i < NUM_FAULTS; i++)
				faults[i] <= faults[i-1];
		end
	end

	// Two second two-key fault clear, one pulse per hold
	wire clrHit = bothHeld && !busy
		&& clrCnt == 32'(CLR_CNT - 1);
	wire clrCount = bothHeld && !busy && !clrHit;
	always_ff @(posedge clk) begin
		if (!rst_n || !bothHeld)
			clrCnt <= 32'h0;
		else if (clrCount)
			clrCnt <= clrCnt + 32'h1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !bothHeld)
			busy <= 1'b0;
		else if (clrHit)
			busy <= 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			faultClear <= 1'b0;
		else
			faultClear <= clrHit;
	end

	// Jog outputs toward the motion path
	wire next_jogOverride = next_jogCw || next_jogCcw;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			jogCw <= 1'b0;
			jogCcw <= 1'b0;
			jogOverride <= 1'b0;
		end else begin
			jogCw <= next_jogCw;
			jogCcw <= next_jogCcw;
			jogOverride <= next_jogOverride;
		end
	end

	// Display value and format
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dispValue <= 20'h0;
			dispFmt <= '0;
		end else begin
			dispValue <= mag;
			dispFmt.digit <= 5'h1F;
			dispFmt.point <= next_point;
			dispFmt.minus <= next_minus;
		end
	end

	// Fault view at the history index
	wire [7:0] next_dispFault = faults[histIdx];
	always_ff @(posedge clk) begin
		if (!rst_n)
			dispFault <= 8'h0;
		else
			dispFault <= next_dispFault;
	end

	assign dispShowCode = mode == KMJT_SHOW;
	assign dispJogPrompt = inJog;
	assign dispSlot = teachMode ? {1'b0, slot} + 4'h1 : 4'h0;
endmodule : kmjt_top

// ===== dv/kmjt_operator.sv
// Operator model: levels of the five panel keys.
// Assumes the bench names the keys to hold.
`timescale 1ns/10ps
module kmjt_operator (
	input wire logic clk,
	input wire logic [4:0] hold,
	output logic [4:0] keyPins
);
	// Keys move just after an edge
	always_ff @(posedge clk) begin
		keyPins <= hold;
	end
endmodule : kmjt_operator

// ===== dv/kmjt_props.sv
// Port checker for the keypad controller.
// Assumes it is bound into kmjt_top.
`timescale 1ns/10ps
module kmjt_props #(
	parameter int CLR_CNT = 50,
	parameter int SHOW_CNT = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [kmjt_pkg::NUM_KEYS-1:0] keyPins,
	input wire kmjt_pkg::kmjt_drive_s drive,
	input wire logic [4:0] monSelect,
	input wire kmjt_pkg::kmjt_fmt_s dispFmt,
	input wire logic dispShowCode,
	input wire logic [3:0] dispSlot,
	input wire logic faultClear,
	input wire logic jogCw,
	input wire logic jogCcw,
	input wire logic jogOverride,
	input wire logic slotWrite
);
	import kmjt_pkg::*;
	int both;
	int shown;
	always_ff @(posedge clk) begin
		both <= (keyPins[KEY_UP] && keyPins[KEY_DOWN]) ? both + 1 : 0;
		shown <= (rst_n && dispShowCode) ? shown + 1 : 0;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	show_time_a: assert property (shown <= SHOW_CNT + 4)
		else $error("code shown too long");
	mon_range_a: assert property (monSelect <= MON_MAX)
		else $error("monitor code out of range");
	five_neg_a: assert property (&dispFmt.point |-> !dispFmt.minus)
		else $error("minus with all points");
	clr_hold_a: assert property (faultClear |-> both >= CLR_CNT)
		else $error("fault cleared early");
	clr_once_a: assert property (faultClear |=> !faultClear)
		else $error("clear not a pulse");
	jog_gate_a: assert property ((jogCw || jogCcw) |->
		$past(drive.driveEnable && !drive.faultStop && !drive.errorPresent))
		else $error("jog while blocked");
	jog_dir_a: assert property (!(jogCw && jogCcw))
		else $error("both jog directions");
	jog_ovr_a: assert property (jogOverride |-> jogCw || jogCcw)
		else $error("override without arrow");
	slot_range_a: assert property (dispSlot <= 4'h8)
		else $error("slot out of range");
	slot_once_a: assert property (slotWrite |=> !slotWrite)
		else $error("slot write not a pulse");
	cover property (faultClear);
	cover property (slotWrite);
	cover property (jogCw && jogOverride);
endmodule : kmjt_props
bind kmjt_top kmjt_props #(.CLR_CNT(CLR_CNT), .SHOW_CNT(SHOW_CNT))
	kmjt_props_inst (.clk(clk), .rst_n(rst_n), .keyPins(keyPins),
	.drive(drive), .monSelect(monSelect), .dispFmt(dispFmt),
	.dispShowCode(dispShowCode), .dispSlot(dispSlot),
	.faultClear(faultClear), .jogCw(jogCw), .jogCcw(jogCcw),
	.jogOverride(jogOverride), .slotWrite(slotWrite));

// ===== dv/tb.sv
// Bench for the keypad monitor, jog and teach controller.
// Assumes short counts and the operator model on the keys.
`timescale 1ns/10ps
module tb;
	import kmjt_pkg::*;
	logic clk = 0, rst_n = 0, cyc = 0, we = 0, ack, fEv = 0;
	logic [7:0] adr = 0, fCode = 0, dFault;
	logic [31:0] dat = 0, rdat, datO;
	logic [4:0] hold = 0, pins, monSel;
	logic [3:0] slot;
	logic [2:0] frac = 0;
	logic five = 0, show, prompt, clr, cw, ccw, ovr, sWr;
	logic signed [19:0] val = 0;
	logic [15:0] jSpd;
	logic [19:0] dVal;
	logic [2:0] sIdxO;
	kmjt_pos_s sDatO;
	kmjt_drive_s drv = 4'h8;
	kmjt_pos_s pos = 0;
	kmjt_fmt_s fmt;
	int errCount = 0, compares = 0, writes = 0, clears = 0;
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		writes <= writes + sWr;
		clears <= clears + clr;
	end
	kmjt_operator kmjt_operator_inst (.clk(clk), .hold(hold), .keyPins(pins));
	kmjt_top #(.SHOW_CNT(20), .CLR_CNT(50), .DEB_CNT(4)) kmjt_top_inst (
		.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
		.wb_dat_o(datO), .wb_ack_o(ack), .keyPins(pins), .drive(drv),
		.monSelStored(5'h06), .faultEvent(fEv), .faultCode(fCode),
		.monValue(val), .monFracDigits(frac), .monFiveDigit(five),
		.absPos(pos), .monSelect(monSel), .dispValue(dVal), .dispFmt(fmt),
		.dispShowCode(show), .dispJogPrompt(prompt), .dispSlot(slot),
		.dispFault(dFault), .faultClear(clr), .jogCw(cw), .jogCcw(ccw),
		.jogSpeed(jSpd), .jogOverride(ovr), .slotWrite(sWr),
		.slotIndex(sIdxO), .slotData(sDatO));
	task automatic chk(input string n, input logic [31:0] e, s);
		compares++;
		if (s !== e) begin
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
			errCount++;
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt
	task automatic bus(input logic w, input logic [7:0] a, input int d);
		int n = 0;
		@(posedge clk);
		cyc <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (!ack && n < 20);
		chk("ack", 1, ack);
		rdat = datO;
		cyc <= 0;
		@(negedge clk);
	endtask : bus
	task automatic key(input logic [4:0] k, input int n);
		@(posedge clk);
		hold <= k;
		repeat (n) @(posedge clk);
		hold <= 0;
		wt(13);
	endtask : key
	task automatic t_mon;
		wt(1);
		chk("show", 1, show);
		wt(3);
		chk("stored", 6, monSel);
		wt(30);
		chk("show", 0, show);
		key(5'h01, 12);
		chk("up", 7, monSel);
		key(5'h02, 12);
		key(5'h02, 12);
		chk("down", 5, monSel);
		bus(1, ADR_MONSEL, 32'h10);
		bus(1, ADR_MONSEL, 32'h11);
		bus(0, ADR_MONSEL, 0);
		chk("monReg", 32'h10, rdat);
		$display("t_mon done");
	endtask : t_mon
	task automatic t_fmt;
		@(posedge clk);
		val <= -20'sh03039;
		five <= 1;
		wt(4);
		chk("pt5", 5'h1F, fmt.point);
		chk("neg5", 0, fmt.minus);
		chk("mag", 20'h03039, dVal);
		chk("digits", 5'h1F, fmt.digit);
		@(posedge clk);
		five <= 0;
		frac <= 3'h2;
		wt(4);
		chk("neg", 1, fmt.minus);
		chk("pts", 1, $countones(fmt.point));
		@(posedge clk);
		val <= 20'sh00929;
		wt(4);
		chk("pos", 0, fmt.minus);
		$display("t_fmt done");
	endtask : t_fmt
	task automatic t_fault;
		for (int i = 1; i < 7; i++) begin
			@(posedge clk);
			fEv <= 1;
			fCode <= 8'hA0 + 8'(i);
			@(posedge clk);
			fEv <= 0;
		end
		bus(0, ADR_FAULT, 0);
		chk("newest", 32'hA6, rdat);
		bus(0, ADR_FAULT + 8'h10, 0);
		chk("fifth", 32'hA2, rdat);
		key(5'h08, 12);
		chk("hist", 8'hA6, dFault);
		key(5'h01, 12);
		chk("hist2", 8'hA5, dFault);
		key(5'h04, 12);
		bus(0, ADR_STATUS, 0);
		chk("histOff", 0, rdat[STAT_HIST]);
		key(5'h03, 30);
		chk("short", 0, clears);
		key(5'h03, 70);
		chk("clear", 1, clears);
		$display("t_fault done");
	endtask : t_fault
	task automatic t_jog;
		bus(1, ADR_JOGSPD, 32'h0123);
		chk("prompt", 1, prompt);
		chk("speed", 16'h0123, jSpd);
		@(posedge clk);
		hold <= 5'h02;
		drv.profileActive <= 1;
		wt(10);
		chk("cw", 2'h2, {cw, ccw});
		chk("ovr", 1, ovr);
		@(posedge clk);
		drv.driveEnable <= 0;
		wt(3);
		chk("gate", 0, cw);
		@(posedge clk);
		drv.driveEnable <= 1;
		hold <= 5'h01;
		wt(10);
		chk("ccw", 2'h1, {cw, ccw});
		@(posedge clk);
		hold <= 0;
		wt(10);
		chk("stop", 0, {cw, ccw, ovr});
		@(posedge clk);
		drv.profileActive <= 0;
		key(5'h04, 12);
		chk("exit", 0, prompt);
		$display("t_jog done");
	endtask : t_jog
	task automatic t_teach;
		bus(1, ADR_AUXFN, 32'h4);
		bus(1, ADR_JOGSPD, 32'h0010);
		chk("slot1", 1, slot);
		@(posedge clk);
		pos <= 32'h00030456;
		key(5'h08, 12);
		chk("slot2", 2, slot);
		chk("sIdx", 0, sIdxO);
		chk("sDat", 32'h00030456, sDatO);
		key(5'h10, 12);
		chk("slot3", 3, slot);
		chk("stores", 1, writes);
		bus(0, ADR_SLOT, 0);
		chk("pos", 32'h00030456, rdat);
		key(5'h04, 12);
		chk("slot0", 0, slot);
		@(posedge clk);
		rst_n <= 0;
		repeat (12) @(posedge clk);
		rst_n <= 1;
		wt(4);
		chk("stored2", 6, monSel);
		bus(0, ADR_SLOT, 0);
		chk("kept", 32'h00030456, rdat);
		$display("t_teach done");
	endtask : t_teach
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, errCount);
		if (errCount == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1;
		t_mon;
		t_fmt;
		t_fault;
		t_jog;
		t_teach;
		report_and_stop;
	end
	initial begin
		#100000;
		errCount++;
		report_and_stop;
	end
endmodule : tb
